// file: hw/vrpm_top.sv
// Refresh store, fetch sequencer and pel mapper of the video adapter.
// Assumes a host memory port, a register port and a monitor on the pins.
`timescale 1ns/1ps
module vrpm_top #(
  parameter int DOT_DIV = vrpm_pkg::DOT_CYCLES
) (
  // Clock, reset, clock enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Host memory window
  input wire logic [19:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Power and panel
  input wire logic ext_power,
  output logic panel_mono_emul,
  // Monitor drive
  output vrpm_pkg::vrpm_video_t video
);
  if (DOT_DIV < 4 || DOT_DIV > 256) begin : g_bad
    $error("vrpm_top: DOT_DIV must be 4 to 256");
  end

  function automatic logic [13:0] mul_add(input logic [13:0] a, input logic [13:0] k,
                                          input logic [13:0] b);
    mul_add = a * k + b;
  endfunction : mul_add

  logic [2:0] pwr_sync;
  logic active;
  logic [7:0] mode;
  logic [7:0] color;
  logic [2:0] page;
  logic [10:0] glyph_idx;
  logic [7:0] div;
  logic [9:0] hcount;
  logic [8:0] vcount;
  logic [5:0] frame;
  vrpm_pkg::vrpm_fetch_t f_state;
  logic [7:0] pend_code;
  logic [7:0] pend_attr;
  logic [7:0] sh_data;
  logic [7:0] sh_attr;
  logic [3:0] gpos;
  logic sh_vis;
  logic hit_q;
  vrpm_pkg::vrpm_rgbi_t next_pel;

  // Power detect
  always_ff @(posedge clk) begin
    if (reset) begin
      pwr_sync <= 3'h0;
      active <= 1'b0;
      panel_mono_emul <= 1'b0;
    end else if (ce) begin
      pwr_sync <= {pwr_sync[1:0], ext_power};
      if (pwr_sync[2] == pwr_sync[1]) begin
        active <= pwr_sync[2];
      end
      panel_mono_emul <= active;
    end
  end

  // Mode decode
  logic gfx;
  logic gfx640;
  logic gfx320;
  logic char80;
  logic wide;
  assign gfx = mode[vrpm_pkg::MODE_GFX];
  assign gfx640 = gfx & mode[vrpm_pkg::MODE_HIRES];
  assign gfx320 = gfx & ~mode[vrpm_pkg::MODE_HIRES];
  assign char80 = ~gfx & mode[vrpm_pkg::MODE_COL80];
  assign wide = ~gfx & ~mode[vrpm_pkg::MODE_COL80];

  // Host window decode and store
  logic mem_hit;
  logic store_wr;
  logic [7:0] store_a_q;
  logic [7:0] store_b_q;
  logic [13:0] disp_addr;
  assign mem_hit = mem_addr >= vrpm_pkg::STORE_BASE && mem_addr < vrpm_pkg::STORE_END;
  assign store_wr = mem_wr & mem_hit & active;

  // Second port serves the display, so host traffic never stalls it
  vrpm_mem #(
    .AW(vrpm_pkg::STORE_AW),
    .DW(8)
  ) u_store (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .a_addr(mem_addr[13:0]),
    .a_wr(store_wr),
    .a_wdata(mem_wdata),
    .a_rdata(store_a_q),
    .b_addr(disp_addr),
    .b_rdata(store_b_q)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      hit_q <= 1'b0;
    end else if (ce) begin
      hit_q <= mem_rd & mem_hit & active;
    end
  end
  assign mem_rdata = hit_q ? store_a_q : 8'h00;

  // Glyph store, loaded through the register port
  logic glyph_wr;
  logic [7:0] glyph_q;
  assign glyph_wr = reg_wr && reg_addr == vrpm_pkg::REG_GLYPH_DATA;

  vrpm_mem #(
    .AW(vrpm_pkg::GLYPH_AW),
    .DW(8)
  ) u_glyph (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .a_addr(glyph_idx),
    .a_wr(glyph_wr),
    .a_wdata(reg_wdata),
    .a_rdata(),
    .b_addr({pend_code, vcount[2:0]}),
    .b_rdata(glyph_q)
  );

  // Register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      mode <= vrpm_pkg::MODE_RST;
      color <= vrpm_pkg::COLOR_RST;
      page <= vrpm_pkg::PAGE_RST;
      glyph_idx <= 11'h000;
    end else if (ce && reg_wr) begin
      unique case (reg_addr)
        vrpm_pkg::REG_MODE: mode <= reg_wdata;
        vrpm_pkg::REG_COLOR: color <= reg_wdata;
        vrpm_pkg::REG_PAGE: page <= reg_wdata[2:0];
        vrpm_pkg::REG_GLYPH_LO: glyph_idx[7:0] <= reg_wdata;
        vrpm_pkg::REG_GLYPH_HI: glyph_idx[10:8] <= reg_wdata[2:0];
        vrpm_pkg::REG_GLYPH_DATA: glyph_idx <= glyph_idx + 11'h001;
        default: glyph_idx <= glyph_idx;
      endcase
    end
  end

  // Register reads
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        unique case (reg_addr)
          vrpm_pkg::REG_MODE: reg_rdata <= mode;
          vrpm_pkg::REG_COLOR: reg_rdata <= color;
          vrpm_pkg::REG_PAGE: reg_rdata <= {5'h00, page};
          vrpm_pkg::REG_STATUS: reg_rdata <= {4'h0, video.vsync, 2'h0, sh_vis};
          vrpm_pkg::REG_GLYPH_LO: reg_rdata <= glyph_idx[7:0];
          vrpm_pkg::REG_GLYPH_HI: reg_rdata <= {5'h00, glyph_idx[10:8]};
          vrpm_pkg::REG_POWER: reg_rdata <= {7'h00, active};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Raster counters
  logic dot_end;
  logic line_end;
  assign dot_end = div == 8'(DOT_DIV - 1);
  assign line_end = hcount == vrpm_pkg::H_TOTAL - 10'h001;

  always_ff @(posedge clk) begin
    if (reset) begin
      div <= 8'h00;
      hcount <= 10'h000;
      vcount <= 9'h000;
      frame <= 6'h00;
    end else if (ce) begin
      div <= dot_end ? 8'h00 : div + 8'h01;
      if (dot_end) begin
        hcount <= line_end ? 10'h000 : hcount + 10'h001;
        if (line_end) begin
          if (vcount == vrpm_pkg::V_TOTAL - 9'h001) begin
            vcount <= 9'h000;
            frame <= frame + 6'h01;
          end else begin
            vcount <= vcount + 9'h001;
          end
        end
      end
    end
  end

  // Fetch address
  logic in_vis;
  logic grp_start;
  logic fetch_go;
  logic [13:0] page_base;
  logic [13:0] char_base;
  logic [13:0] gfx_base;
  logic [13:0] fetch_base;
  logic [13:0] col;
  assign in_vis = hcount < vrpm_pkg::H_VIS && vcount < vrpm_pkg::V_VIS;
  assign grp_start = wide ? hcount[3:0] == 4'h0 : hcount[2:0] == 3'h0;
  assign fetch_go = div == 8'h00 && in_vis && grp_start && f_state == vrpm_pkg::FETCH_IDLE;
  assign col = wide ? {8'h00, hcount[9:4]} : {7'h00, hcount[9:3]};
  assign page_base = char80 ? {page[1:0], 12'h000} : {page[2:0], 11'h000};
  logic [13:0] char_pos;
  assign char_pos = mul_add({9'h000, vcount[7:3]},
                            char80 ? vrpm_pkg::COLS_HI : vrpm_pkg::COLS_LO, col);
  assign char_base = page_base + {char_pos[12:0], 1'b0};
  // above: two bytes per position, row-major from the page start
  assign gfx_base = (vcount[0] ? vrpm_pkg::ODD_BANK : 14'h0000)
                  + mul_add({6'h00, vcount[8:1]}, vrpm_pkg::GFX_LINE,
                            {7'h00, hcount[9:3]});
  assign fetch_base = gfx ? gfx_base : char_base;
  assign disp_addr = f_state == vrpm_pkg::FETCH_BYTE0 ? fetch_base + 14'h0001 : fetch_base;
  // above: the attribute byte follows its code byte

  // Fetch sequencer, four clocks, done within one dot
  always_ff @(posedge clk) begin
    if (reset) begin
      f_state <= vrpm_pkg::FETCH_IDLE;
    end else if (ce) begin
      unique case (f_state)
        vrpm_pkg::FETCH_IDLE: if (fetch_go) f_state <= vrpm_pkg::FETCH_BYTE0;
        vrpm_pkg::FETCH_BYTE0: f_state <= vrpm_pkg::FETCH_BYTE1;
        vrpm_pkg::FETCH_BYTE1: f_state <= vrpm_pkg::FETCH_GLYPH;
        vrpm_pkg::FETCH_GLYPH: f_state <= vrpm_pkg::FETCH_IDLE;
        default: f_state <= vrpm_pkg::FETCH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pend_code <= 8'h00;
      pend_attr <= 8'h00;
    end else if (ce) begin
      if (f_state == vrpm_pkg::FETCH_BYTE0) pend_code <= store_b_q;
      if (f_state == vrpm_pkg::FETCH_BYTE1) pend_attr <= store_b_q;
    end
  end

  // Dot shifter
  always_ff @(posedge clk) begin
    if (reset) begin
      sh_data <= 8'h00;
      sh_attr <= 8'h00;
      gpos <= 4'h0;
      sh_vis <= 1'b0;
    end else if (ce && dot_end) begin
      sh_vis <= in_vis;
      if (in_vis && grp_start) begin
        // Glyph row is taken straight from the glyph read register, valid by dot end
        sh_data <= gfx ? pend_code : glyph_q;
        sh_attr <= pend_attr;
        gpos <= 4'h0;
      end else begin
        gpos <= gpos + 4'h1;
      end
    end
  end

  // Pel colour
  logic [2:0] bidx;
  logic [1:0] pidx;
  logic dotbit;
  logic [1:0] pv;
  logic fg_on;
  vrpm_pkg::vrpm_attr_t attr;
  assign bidx = wide ? gpos[3:1] : gpos[2:0];
  assign dotbit = sh_data[~bidx];
  assign pidx = gpos[2:1];
  assign pv = {sh_data[{~pidx, 1'b1}], sh_data[{~pidx, 1'b0}]};
  assign attr = vrpm_pkg::vrpm_attr_t'(sh_attr);
  assign fg_on = dotbit & ~(mode[vrpm_pkg::MODE_BLINK] & attr.blink
                 & frame[vrpm_pkg::BLINK_BIT]);

  always_comb begin
    next_pel = '0;
    if (gfx640) begin
      next_pel = dotbit ? vrpm_pkg::vrpm_rgbi_t'(color[3:0]) : '0;
    end else if (gfx320) begin
      if (pv == 2'h0) begin
        next_pel = vrpm_pkg::vrpm_rgbi_t'(color[3:0]);
      end else begin
        next_pel = {color[vrpm_pkg::COLOR_ALT_I], pv[1], pv[0],
                    color[vrpm_pkg::COLOR_SET]};
      end
    end else if (fg_on) begin
      next_pel = {attr.inten, attr.fg};
    end else begin
      next_pel = {~mode[vrpm_pkg::MODE_BLINK] & attr.blink, attr.bg};
    end
    if (mode[vrpm_pkg::MODE_BW] && !gfx640) begin
      next_pel.r = next_pel.r | next_pel.g | next_pel.b;
      next_pel.g = next_pel.r;
      next_pel.b = next_pel.r;
    end
    if (!sh_vis || !mode[vrpm_pkg::MODE_VIDEN] || !active) begin
      next_pel = '0;
    end
  end

  // Monitor outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      video <= '0;
    end else if (ce && dot_end) begin
      video.pel <= next_pel;
      video.hsync <= active && hcount >= vrpm_pkg::H_SYNC_START
                     && hcount < vrpm_pkg::H_SYNC_END;
      video.vsync <= active && vcount >= vrpm_pkg::V_SYNC_START
                     && vcount < vrpm_pkg::V_SYNC_END;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !ce);

  a_read_miss_zero: assert property (mem_rd && !mem_hit |=> mem_rdata == 8'h00)
    else $error("read outside window returned data");
  a_store_write_read: assert property ((store_wr ##1 (mem_rd && mem_hit && active
      && mem_addr == $past(mem_addr) && !mem_wr)) |=> mem_rdata == $past(mem_wdata, 2))
    else $error("store did not return written byte");
  a_attr_follows: assert property (f_state == vrpm_pkg::FETCH_BYTE0
      |-> disp_addr == $past(disp_addr) + 14'h0001)
    else $error("attribute not fetched from next byte");
  a_fetch_bounded: assert property (fetch_go |-> ##3 f_state == vrpm_pkg::FETCH_GLYPH
      ##1 f_state == vrpm_pkg::FETCH_IDLE)
    else $error("display fetch overran its slot");
  a_char_extent: assert property (fetch_go && !gfx |-> (fetch_base - page_base)
      <= (char80 ? vrpm_pkg::LAST_HI : vrpm_pkg::LAST_LO))
    else $error("character fetch beyond screen");
  a_gfx_bank: assert property (fetch_go && gfx |-> fetch_base[13] == vcount[0]
      && fetch_base[12:0] < vrpm_pkg::BANK_BYTES)
    else $error("graphics row from wrong bank");
  a_gfx_origin: assert property (fetch_go && gfx && hcount == 10'h000 && vcount == 9'h000
      |-> fetch_base == 14'h0000)
    else $error("upper-left pel not from first byte");
  a_hires_onoff: assert property (dot_end && gfx640 && sh_vis && active
      && mode[vrpm_pkg::MODE_VIDEN] |=> video.pel == ($past(dotbit)
      ? vrpm_pkg::vrpm_rgbi_t'($past(color[3:0])) : 4'h0))
    else $error("640 pel not on or off per bit");
  a_pair_colour: assert property (dot_end && gfx320 && sh_vis && active && pv != 2'h0
      && mode[vrpm_pkg::MODE_VIDEN] && !mode[vrpm_pkg::MODE_BW]
      |=> video.pel[2:0] == {$past(pv), $past(color[vrpm_pkg::COLOR_SET])})
    else $error("wrong colour set mapping");
  a_intensity: assert property (dot_end && !gfx && sh_vis && active && fg_on
      && mode[vrpm_pkg::MODE_VIDEN] |=> video.pel.i == $past(attr.inten))
    else $error("intensity output does not follow attribute");
  a_dark_unpowered: assert property (!active && dot_end |=> video == '0)
    else $error("video driven without external power");
  a_status_vsync: assert property (reg_rd && reg_addr == vrpm_pkg::REG_STATUS
      |=> reg_rdata[vrpm_pkg::STAT_VSYNC] == $past(video.vsync))
    else $error("status vsync mismatch");

  c_char80: cover property (fetch_go && char80);
  c_char40: cover property (fetch_go && wide);
  c_gfx320_odd: cover property (fetch_go && gfx320 && vcount[0]);
  c_page: cover property (fetch_go && !gfx && page != 3'h0);
endmodule : vrpm_top

// file: hw/vrpm_pkg.sv
// Constants, types and register map of the video refresh pel mapper.
// Assumes one clock domain; every user names items as vrpm_pkg::name.
// Overview of operation
// - A 16K-byte refresh store; character mode has 256 character codes.
// - The store is decoded at host memory address b8000 upward.
// - Character codes pass through a glyph store giving 8-by-8 dot cells.
// - Character screens are 25 rows of 40 or 80 characters.
// - Graphics is 320x200 colour or 640x200 in one colour-register colour on black.
// - Each character is an even code byte followed by its odd attribute byte.
// - A set intensity attribute bit drives the intensity output for that colour.
// - A colour field's low three bits drive blue, green and red.
// - A character screen spans 2000 bytes at 40 columns, 4000 at 80.
// - Eight 40-column or four 80-column pages; any page may be shown.
// - The 80-column screen runs from b8000 sequentially to b8f9f.
// - Graphics even rows come from bank b8000, odd rows from ba000.
// - First even-bank byte feeds the upper-left pels, advancing sequentially.
// - In 640-pel graphics each bit switches one physical pel on or off.
// - In 320-pel graphics bit pairs form pels two dots wide, bits 7:6 first.
// - Pel values 1-3 give green, red, brown or cyan, magenta, white.
// - Red, green, blue, intensity and active-high vertical and horizontal sync outputs.
// - Works only on external power; the panel then emulates a monochrome adapter.
// - Host store accesses never disturb display fetches; no blanking needed.
// - Mode bit 4 selects 640 graphics; other bits select mode, colour, width, enable, blink.
package vrpm_pkg;
  // Store geometry
  localparam int STORE_AW = 14;
  localparam int GLYPH_AW = 11;
  localparam logic [19:0] STORE_BASE = 20'hb8000;
  localparam logic [19:0] STORE_END = 20'hbc000;
  localparam logic [13:0] ODD_BANK = 14'h2000;
  localparam logic [13:0] GFX_LINE = 14'h0050;
  localparam logic [13:0] COLS_LO = 14'h0028;
  localparam logic [13:0] COLS_HI = 14'h0050;
  localparam logic [13:0] LAST_LO = 14'h07ce;
  localparam logic [13:0] LAST_HI = 14'h0f9e;
  localparam logic [12:0] BANK_BYTES = 13'h1f40;
  // Raster, in dots and lines
  localparam logic [9:0] H_VIS = 10'h280;
  localparam logic [9:0] H_TOTAL = 10'h320;
  localparam logic [9:0] H_SYNC_START = 10'h290;
  localparam logic [9:0] H_SYNC_END = 10'h2f0;
  localparam logic [8:0] V_VIS = 9'h0c8;
  localparam logic [8:0] V_TOTAL = 9'h106;
  localparam logic [8:0] V_SYNC_START = 9'h0e0;
  localparam logic [8:0] V_SYNC_END = 9'h0e3;
  localparam int BLINK_BIT = 4;
  // Dot period
  localparam int DOT_NS = 64;
  localparam int CLK_MHZ = 250;
  localparam int DOT_CYCLES = DOT_NS * CLK_MHZ / 1000;
  // Register offsets
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_COLOR = 4'h1;
  localparam logic [3:0] REG_PAGE = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_GLYPH_LO = 4'h4;
  localparam logic [3:0] REG_GLYPH_HI = 4'h5;
  localparam logic [3:0] REG_GLYPH_DATA = 4'h6;
  localparam logic [3:0] REG_POWER = 4'h7;
  // Mode control fields
  localparam int MODE_COL80 = 0;
  localparam int MODE_GFX = 1;
  localparam int MODE_BW = 2;
  localparam int MODE_VIDEN = 3;
  localparam int MODE_HIRES = 4;
  localparam int MODE_BLINK = 5;
  // Colour select fields
  localparam int COLOR_ALT_I = 4;
  localparam int COLOR_SET = 5;
  // Status fields
  localparam int STAT_DISP_EN = 0;
  localparam int STAT_VSYNC = 3;
  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] COLOR_RST = 8'h00;
  localparam logic [2:0] PAGE_RST = 3'h0;

  typedef struct packed {
    logic i;
    logic r;
    logic g;
    logic b;
  } vrpm_rgbi_t;

  typedef struct packed {
    logic hsync;
    logic vsync;
    vrpm_rgbi_t pel;
  } vrpm_video_t;

  typedef struct packed {
    logic blink;
    logic [2:0] bg;
    logic inten;
    logic [2:0] fg;
  } vrpm_attr_t;

  typedef enum logic [3:0] {
    FETCH_IDLE = 4'h1,
    FETCH_BYTE0 = 4'h2,
    FETCH_BYTE1 = 4'h4,
    FETCH_GLYPH = 4'h8
  } vrpm_fetch_t;
endpackage : vrpm_pkg

// file: hw/vrpm_mem.sv
// Byte memory with one read-write port and one read-only port.
// Both read data come out of registers one cycle after the address.
`timescale 1ns/1ps
module vrpm_mem #(
  parameter int AW = 14,
  parameter int DW = 8
) (
  // Clock and control
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Read-write port
  input wire logic [AW-1:0] a_addr,
  input wire logic a_wr,
  input wire logic [DW-1:0] a_wdata,
  output logic [DW-1:0] a_rdata,
  // Read-only port
  input wire logic [AW-1:0] b_addr,
  output logic [DW-1:0] b_rdata
);
  if (AW < 1 || AW > 16 || DW < 1) begin : g_bad
    $error("vrpm_mem: unsupported size");
  end

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (ce && a_wr) begin
      mem[a_addr] <= a_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      a_rdata <= '0;
      b_rdata <= '0;
    end else if (ce) begin
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
    end
  end
endmodule : vrpm_mem

// file: tb/vrpm_monitor.sv
// Passive model of the direct-drive monitor on the far side of the adapter.
// Assumes the video bundle is sampled on the adapter clock; it never drives back.
`timescale 1ns/1ps
module vrpm_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Video from the adapter
  input wire vrpm_pkg::vrpm_video_t video,
  // Capture control and results
  input wire logic clear,
  output logic [15:0] seen,
  output logic unknown,
  output int period,
  output int width,
  output int hrises
);
  int cnt;
  int hi;
  logic hs_d;

  // Line period and sync width, counted in clocks; sync taken as active high
  always @(posedge clk) begin
    if (reset) begin
      hs_d <= 1'b0;
      cnt <= 0;
      hi <= 0;
      hrises <= 0;
    end else begin
      hs_d <= video.hsync;
      cnt <= cnt + 1;
      if (video.hsync) hi <= hi + 1;
      if (video.hsync && !hs_d) begin
        period <= cnt;
        cnt <= 1;
        hrises <= hrises + 1;
      end
      if (!video.hsync && hs_d) begin
        width <= hi;
        hi <= 0;
      end
    end
  end

  // Set of colour codes shown since the last clear
  always @(posedge clk) begin
    if (clear) begin
      seen <= 16'h0000;
      unknown <= 1'b0;
    end else if ($isunknown(video.pel)) begin
      unknown <= 1'b1;
    end else begin
      seen[video.pel] <= 1'b1;
    end
  end
endmodule : vrpm_monitor

// file: tb/tb.sv
// Self-checking bench for the video refresh pel mapper.
// Assumes a shortened dot divider so that several raster lines fit in the run.
`timescale 1ns/1ps
module tb;
  localparam int DD = 4;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic [19:0] mem_addr = 20'h00000;
  logic mem_wr = 1'b0;
  logic mem_rd = 1'b0;
  logic [7:0] mem_wdata = 8'h00;
  logic [7:0] mem_rdata;
  logic [3:0] reg_addr = 4'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic ext_power = 1'b1;
  logic panel_mono_emul;
  vrpm_pkg::vrpm_video_t video;
  logic clear = 1'b1;
  logic [15:0] seen;
  logic unknown;
  int period;
  int width;
  int hrises;
  int failures = 0;
  int n_checks = 0;
  logic [7:0] d;
  logic [5:0] acc;

  always #2 clk = ~clk;

  vrpm_top #(.DOT_DIV(DD)) DUT (.clk(clk), .reset(reset), .ce(ce), .mem_addr(mem_addr),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .ext_power(ext_power), .panel_mono_emul(panel_mono_emul),
    .video(video));

  vrpm_monitor mon (.clk(clk), .reset(reset), .video(video), .clear(clear), .seen(seen),
    .unknown(unknown), .period(period), .width(width), .hrises(hrises));

  task automatic results;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : reg_read

  task automatic mem_write(input logic [19:0] a, input logic [7:0] v);
    @(posedge clk);
    mem_addr <= a;
    mem_wdata <= v;
    mem_wr <= 1'b1;
    @(posedge clk);
    mem_wr <= 1'b0;
  endtask : mem_write

  task automatic mem_read(input logic [19:0] a, output logic [7:0] v);
    @(posedge clk);
    mem_addr <= a;
    mem_rd <= 1'b1;
    @(posedge clk);
    mem_rd <= 1'b0;
    #1 v = mem_rdata;
  endtask : mem_read

  // Waits for the next horizontal sync pulse, with a bound of several lines
  task automatic wait_line;
    int h0;
    int n;
    h0 = hrises;
    n = 0;
    while (hrises == h0 && n < 4000 * DD) begin
      @(posedge clk);
      n++;
    end
    if (hrises == h0) begin
      failures++;
      $display("CHECK FAILED hsync expected pulse seen none");
      results();
    end
  endtask : wait_line

  // Sets a mode, then gathers the colour codes of one whole line
  task automatic show(input string what, input logic [7:0] m, input logic [7:0] c,
                      input logic [15:0] exp);
    reg_write(vrpm_pkg::REG_MODE, m);
    reg_write(vrpm_pkg::REG_COLOR, c);
    wait_line();
    @(posedge clk);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    wait_line();
    check(what, seen, exp);
    check("pel unknown", unknown, 0);
  endtask : show

  task automatic test_regs;
    reg_read(vrpm_pkg::REG_MODE, d);
    check("mode reset", d, 8'h00);
    reg_read(vrpm_pkg::REG_COLOR, d);
    check("colour reset", d, 8'h00);
    reg_read(vrpm_pkg::REG_PAGE, d);
    check("page reset", d, 8'h00);
    reg_write(vrpm_pkg::REG_MODE, 8'h3f);
    reg_read(vrpm_pkg::REG_MODE, d);
    check("mode rw", d, 8'h3f);
    reg_write(vrpm_pkg::REG_PAGE, 8'h07);
    reg_read(vrpm_pkg::REG_PAGE, d);
    check("page rw", d, 8'h07);
    reg_write(4'h8, 8'hff);
    reg_read(4'h8, d);
    check("unmapped", d, 8'h00);
    reg_write(vrpm_pkg::REG_MODE, 8'h00);
    reg_write(vrpm_pkg::REG_PAGE, 8'h00);
    $display("test regs done");
  endtask : test_regs

  task automatic test_mem;
    logic [19:0] hits [5];
    hits = '{20'hb8000, 20'hb8001, 20'hb87cf, 20'hba000, 20'hbbfff};
    foreach (hits[i]) mem_write(hits[i], hits[i][7:0] ^ 8'h5a);
    mem_write(20'hbc000, 8'h33);
    mem_write(20'hb7fff, 8'h33);
    foreach (hits[i]) begin
      mem_read(hits[i], d);
      check("store byte", d, hits[i][7:0] ^ 8'h5a);
    end
    mem_read(20'hbc000, d);
    check("miss above", d, 8'h00);
    mem_read(20'hb7fff, d);
    check("miss below", d, 8'h00);
    $display("test mem done");
  endtask : test_mem

  task automatic test_power;
    check("panel on", panel_mono_emul, 1'b1);
    ext_power <= 1'b0;
    repeat (8) @(posedge clk);
    check("panel off", panel_mono_emul, 1'b0);
    reg_read(vrpm_pkg::REG_POWER, d);
    check("power flag", d, 8'h00);
    mem_write(20'hb8000, 8'h77);
    mem_read(20'hb8000, d);
    check("read unpowered", d, 8'h00);
    acc = 6'h00;
    repeat (800 * DD) begin
      @(posedge clk);
      acc = acc | video;
    end
    check("video unpowered", acc, 6'h00);
    ext_power <= 1'b1;
    repeat (8) @(posedge clk);
    reg_read(vrpm_pkg::REG_POWER, d);
    check("power back", d, 8'h01);
    mem_read(20'hb8000, d);
    check("write dropped", d, 8'h5a);
    $display("test power done");
  endtask : test_power

  task automatic test_video;
    // Even bytes are code ff with a full glyph, odd bytes attribute 1c
    @(posedge clk);
    for (int i = 0; i < 16384; i++) begin
      mem_addr <= 20'hb8000 + 20'(i);
      mem_wdata <= i[0] ? 8'h1c : 8'hff;
      mem_wr <= 1'b1;
      @(posedge clk);
    end
    mem_wr <= 1'b0;
    reg_write(vrpm_pkg::REG_GLYPH_LO, 8'hf8);
    reg_write(vrpm_pkg::REG_GLYPH_HI, 8'h07);
    repeat (8) reg_write(vrpm_pkg::REG_GLYPH_DATA, 8'hff);
    reg_read(vrpm_pkg::REG_GLYPH_DATA, d);
    check("glyph data read", d, 8'h00);
    show("hires blue", 8'h1a, 8'h09, 16'h0201);
    check("line period", period, 800 * DD);
    check("hsync width", width, 96 * DD);
    reg_read(vrpm_pkg::REG_STATUS, d);
    check("status vsync", d[3], video.vsync);
    show("hires red", 8'h1a, 8'h0c, 16'h1001);
    show("medium set one", 8'h0a, 8'h00, 16'h0045);
    show("medium set two", 8'h0a, 8'h20, 16'h0089);
    show("medium mono", 8'h0e, 8'h00, 16'h0081);
    show("text 80", 8'h09, 8'h00, 16'h1001);
    show("text 40", 8'h08, 8'h00, 16'h1001);
    show("video off", 8'h12, 8'h0f, 16'h0001);
    $display("test video done");
  endtask : test_video

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    clear <= 1'b0;
    repeat (8) @(posedge clk);
    test_regs();
    test_mem();
    test_power();
    test_video();
    results();
  end
endmodule : tb
